// ---- hdl/jcf_jtag_char_port.sv ----
// How it works
// - data read pops oldest character, low byte
// - bit 15 marks the returned character valid
// - bits 16 up give count left after pop
// - data write pushes low byte toward host
// - write into full fifo is silently dropped
// - control bits 0,1 are read/write enables
// - bits 8,9 show enabled pending conditions
// - bit 10 set on host poll, write-1 clears
// - control bits 16 up give write free slots
// - control writes touch only enables and bit 10
// - one active-high interrupt from enabled pendings
// - write condition while fill at most threshold
// - read condition while free at most threshold
// - read condition also when host sends no more and characters wait
// - read condition cleared only by popping characters, by end of stream dropping or by reset
// - both thresholds default to eight characters
`timescale 1ns/1ps
module jcf_jtag_char_port import jcf_pkg::*; #(
    parameter int FIFO_AW   = FIFO_AW_DEF,
    parameter int RD_THRESH = RD_THRESH_DEF,
    parameter int WR_THRESH = WR_THRESH_DEF
) (
    // system clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic              reg_cs,
    input  wire logic [0:0]        reg_addr,
    input  wire logic              reg_rd,
    input  wire logic              reg_wr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rdvalid,
    // interrupt
    output logic                   irq,
    // host link, scan clock domain
    input  wire logic              tck,
    input  wire logic              host_wr_valid,
    input  wire logic [CHAR_W-1:0] host_wr_data,
    output logic                   host_wr_ready,
    input  wire logic              host_rd_req,
    output logic      [CHAR_W-1:0] host_rd_data,
    output logic                   host_rd_strobe,
    output logic                   host_rd_avail,
    input  wire logic              host_poll,
    input  wire logic              host_eof
);
    localparam int               DEPTH   = 1 << FIFO_AW;
    localparam logic [FIFO_AW:0] DEPTH_V = (FIFO_AW+1)'(DEPTH);
    localparam logic [FIFO_AW:0] RD_TH_V = (FIFO_AW+1)'(RD_THRESH);
    localparam logic [FIFO_AW:0] WR_TH_V = (FIFO_AW+1)'(WR_THRESH);

    generate
        if (FIFO_AW < 1 || FIFO_AW > COUNT_W - 1) begin : g_bad_aw
            $error("FIFO_AW must lie in 1..15");
        end
        if (RD_THRESH < 0 || RD_THRESH >= DEPTH || WR_THRESH < 0 || WR_THRESH >= DEPTH) begin : g_bad_th
            $error("thresholds must be below the fifo depth");
        end
    endgenerate

    // register decode, shared by reads and writes
    function automatic logic hit(input logic [0:0] idx);
        return reg_cs && (reg_addr == idx);
    endfunction

    typedef struct packed {
        logic        re;
        logic        we;
        logic        ac;
        logic        irq;
        logic [31:0] rdata;
        logic        rdvalid;
        logic        poll_seen;
    } jcf_sys_st_t;

    typedef struct packed {
        logic              poll_tgl;
        logic [CHAR_W-1:0] rd_data;
        logic              rd_strobe;
    } jcf_tck_st_t;

    jcf_sys_st_t s_ff;
    jcf_sys_st_t nxt_s;
    jcf_tck_st_t t_ff;
    jcf_tck_st_t nxt_t;

    // fifo wiring
    logic              tck_rst;
    logic              rf_w_ready;
    logic              rf_r_valid;
    logic [CHAR_W-1:0] rf_r_data;
    logic [FIFO_AW:0]  rf_r_count;
    logic              wf_w_ready;
    logic [FIFO_AW:0]  wf_w_count;
    logic              wf_r_valid;
    logic [CHAR_W-1:0] wf_r_data;
    logic              poll_s;
    logic              eof_s;
    logic              rd_data_hit;
    logic              rd_ctrl_hit;
    logic              wr_data_hit;
    logic              wr_ctrl_hit;
    logic              pop;
    logic              push;
    logic              host_push;
    logic              host_pop;
    logic              rcond;
    logic              wcond;
    logic              ri;
    logic              wi;
    logic              ac_set;
    logic [FIFO_AW:0]  wf_free;
    logic [FIFO_AW:0]  rf_left;

    // reset reaches the scan domain through a synchroniser; needs tck running
    jcf_sync #(.W(1)) u_rst_t (.clk(tck), .rst(1'b0), .d(sys_rst), .q(tck_rst));
    // poll toggle and end-of-stream level cross into the bus domain
    jcf_sync #(.W(1)) u_poll  (.clk(clk), .rst(sys_rst), .d(t_ff.poll_tgl), .q(poll_s));
    jcf_sync #(.W(1)) u_eof   (.clk(clk), .rst(sys_rst), .d(host_eof), .q(eof_s));

    // host to bus
    jcf_afifo #(.DW(CHAR_W), .AW(FIFO_AW)) u_rd_fifo (
        .wclk    (tck),
        .wrst    (tck_rst),
        .w_push  (host_push),
        .w_data  (host_wr_data),
        .w_ready (rf_w_ready),
        .w_count (),
        .rclk    (clk),
        .rrst    (sys_rst),
        .r_pop   (pop),
        .r_valid (rf_r_valid),
        .r_data  (rf_r_data),
        .r_count (rf_r_count)
    );

    // bus to host
    jcf_afifo #(.DW(CHAR_W), .AW(FIFO_AW)) u_wr_fifo (
        .wclk    (clk),
        .wrst    (sys_rst),
        .w_push  (push),
        .w_data  (reg_wdata[DATA_LSB +: CHAR_W]),
        .w_ready (wf_w_ready),
        .w_count (wf_w_count),
        .rclk    (tck),
        .rrst    (tck_rst),
        .r_pop   (host_pop),
        .r_valid (wf_r_valid),
        .r_data  (wf_r_data),
        .r_count ()
    );

    // bus-side decode and interrupt conditions
    always_comb begin
        rd_data_hit = hit(DATA_REG_IDX) && reg_rd;
        rd_ctrl_hit = hit(CTRL_REG_IDX) && reg_rd;
        wr_data_hit = hit(DATA_REG_IDX) && reg_wr;
        wr_ctrl_hit = hit(CTRL_REG_IDX) && reg_wr;
        pop         = rd_data_hit && rf_r_valid;
        push        = wr_data_hit && wf_w_ready;
        wf_free     = DEPTH_V - wf_w_count;
        rf_left     = rf_r_count - (FIFO_AW+1)'(pop);
        // levels only: popping, a drop of end-of-stream or reset are the ways to drop the read condition
        rcond       = ((DEPTH_V - rf_r_count) <= RD_TH_V)
                      || ((rf_r_count != '0) && eof_s);
        wcond       = wf_w_count <= WR_TH_V;
        ri          = s_ff.re && rcond;
        wi          = s_ff.we && wcond;
        ac_set      = poll_s ^ s_ff.poll_seen;
    end

    always_comb begin
        nxt_s           = s_ff;
        nxt_s.poll_seen = poll_s;
        nxt_s.rdvalid   = reg_cs && reg_rd;
        if (wr_ctrl_hit) begin
            nxt_s.re = reg_wdata[RE_BIT];
            nxt_s.we = reg_wdata[WE_BIT];
            if (reg_wdata[AC_BIT]) begin
                nxt_s.ac = 1'b0;
            end
        end
        // a poll in the clearing cycle still sets the flag
        if (ac_set) begin
            nxt_s.ac = 1'b1;
        end
        nxt_s.irq = ri || wi;
        if (rd_data_hit) begin
            nxt_s.rdata = '0;
            if (rf_r_valid) begin
                nxt_s.rdata[DATA_LSB +: CHAR_W] = rf_r_data;
            end
            nxt_s.rdata[RVALID_BIT] = rf_r_valid;
            nxt_s.rdata[COUNT_LSB +: COUNT_W] = COUNT_W'(rf_left);
        end else if (rd_ctrl_hit) begin
            nxt_s.rdata = '0;
            nxt_s.rdata[RE_BIT] = s_ff.re;
            nxt_s.rdata[WE_BIT] = s_ff.we;
            nxt_s.rdata[RI_BIT] = ri;
            nxt_s.rdata[WI_BIT] = wi;
            nxt_s.rdata[AC_BIT] = s_ff.ac;
            nxt_s.rdata[COUNT_LSB +: COUNT_W] = COUNT_W'(wf_free);
        end
        if (sys_rst) begin
            nxt_s           = '0;
            nxt_s.re        = RE_RST;
            nxt_s.we        = WE_RST;
            nxt_s.ac        = AC_RST;
            nxt_s.irq       = IRQ_RST;
            nxt_s.poll_seen = poll_s;
        end
    end

    always_ff @(posedge clk) begin
        s_ff <= nxt_s;
    end

    // scan-side logic
    always_comb begin
        host_push       = host_wr_valid && rf_w_ready;
        host_pop        = host_rd_req && wf_r_valid;
        nxt_t           = t_ff;
        nxt_t.rd_strobe = host_pop;
        if (host_pop) begin
            nxt_t.rd_data = wf_r_data;
        end
        // events cross as a toggle so none is lost between clocks
        if (host_poll) begin
            nxt_t.poll_tgl = ~t_ff.poll_tgl;
        end
        if (tck_rst) begin
            nxt_t = '0;
        end
    end

    always_ff @(posedge tck) begin
        t_ff <= nxt_t;
    end

    assign reg_rdata      = s_ff.rdata;
    assign reg_rdvalid    = s_ff.rdvalid;
    assign irq            = s_ff.irq;
    assign host_wr_ready  = rf_w_ready;
    assign host_rd_avail  = wf_r_valid;
    assign host_rd_data   = t_ff.rd_data;
    assign host_rd_strobe = t_ff.rd_strobe;

    // checks
    logic irq_cause;
    assign irq_cause = (s_ff.re && rcond) || (s_ff.we && wcond);

    pop_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_data_hit && rf_r_valid) |=> reg_rdvalid && reg_rdata[RVALID_BIT])
        else $error("read of a waiting character not flagged valid");

    empty_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_data_hit && !rf_r_valid) |=> !reg_rdata[RVALID_BIT] && (reg_rdata[COUNT_LSB +: COUNT_W] == '0))
        else $error("empty read returned a valid flag");

    count_after_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_data_hit && rf_r_valid) |=>
            (reg_rdata[COUNT_LSB +: COUNT_W] == COUNT_W'($past(rf_r_count) - (FIFO_AW+1)'(1))))
        else $error("remaining count is not one less than before the pop");

    push_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_data_hit && wf_w_ready) |=> (wf_w_count != '0))
        else $error("write fifo empty after accepted push");

    enable_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctrl_hit |=> (s_ff.re == $past(reg_wdata[RE_BIT])) && (s_ff.we == $past(reg_wdata[WE_BIT])))
        else $error("interrupt enables did not follow control write");

    pend_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_ctrl_hit |=> (reg_rdata[RI_BIT] == $past(ri)) && (reg_rdata[WI_BIT] == $past(wi))
            && (reg_rdata[COUNT_LSB +: COUNT_W] == COUNT_W'($past(wf_free))))
        else $error("control read fields wrong");

    act_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_ctrl_hit && reg_wdata[AC_BIT] && !ac_set) |=> !s_ff.ac)
        else $error("activity flag not cleared by write of one");

    act_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        ac_set |=> s_ff.ac)
        else $error("host poll lost");

    act_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_ff.ac && !(wr_ctrl_hit && reg_wdata[AC_BIT])) |=> s_ff.ac)
        else $error("activity flag dropped without a clearing write");

    irq_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 (irq == $past(irq_cause)))
        else $error("interrupt output does not follow enabled conditions");

    wr_cond_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_ff.we && (wf_w_count <= WR_TH_V)) |=> irq)
        else $error("write condition did not raise interrupt");

    rd_full_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_ff.re && (rf_r_count >= DEPTH_V - RD_TH_V)) |=> irq)
        else $error("nearly full read fifo did not raise interrupt");

    rd_eof_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s_ff.re && eof_s && rf_r_valid) |=> irq)
        else $error("end of stream with data did not raise interrupt");

    reset_clear_a: assert property (@(posedge clk)
        sys_rst |=> !irq && !s_ff.re && !s_ff.we && !s_ff.ac && !rf_r_valid)
        else $error("reset left state behind");

    host_pop_a: assert property (@(posedge tck) disable iff (tck_rst)
        (host_rd_req && wf_r_valid) |=> host_rd_strobe && (host_rd_data == $past(wf_r_data)))
        else $error("host read did not deliver the character");
endmodule

// ---- hdl/jcf_pkg.sv ----
package jcf_pkg;
    // register indices; byte address is four times the index
    localparam logic [0:0] DATA_REG_IDX = 1'h0;
    localparam logic [0:0] CTRL_REG_IDX = 1'h1;

    // field positions
    localparam int CHAR_W      = 8;
    localparam int DATA_LSB    = 0;
    localparam int RVALID_BIT  = 15;
    localparam int COUNT_LSB   = 16;
    localparam int COUNT_W     = 16;
    localparam int RE_BIT      = 0;
    localparam int WE_BIT      = 1;
    localparam int RI_BIT      = 8;
    localparam int WI_BIT      = 9;
    localparam int AC_BIT      = 10;

    // reset values
    localparam logic RE_RST    = 1'h0;
    localparam logic WE_RST    = 1'h0;
    localparam logic AC_RST    = 1'h0;
    localparam logic IRQ_RST   = 1'h0;

    // build-time defaults
    localparam int FIFO_AW_DEF   = 6;
    localparam int RD_THRESH_DEF = 8;
    localparam int WR_THRESH_DEF = 8;
endpackage

// ---- hdl/jcf_sync.sv ----
`timescale 1ns/1ps
module jcf_sync import jcf_pkg::*; #(
    parameter int W = 1
) (
    // destination clock
    input  wire logic         clk,
    input  wire logic         rst,
    // crossing data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } jcf_sync_st_t;

    jcf_sync_st_t st_ff;
    jcf_sync_st_t nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        if (rst) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign q = st_ff.s2;
endmodule

// ---- hdl/jcf_afifo.sv ----
`timescale 1ns/1ps
module jcf_afifo import jcf_pkg::*; #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    // write side
    input  wire logic          wclk,
    input  wire logic          wrst,
    input  wire logic          w_push,
    input  wire logic [DW-1:0] w_data,
    output logic               w_ready,
    output logic [AW:0]        w_count,
    // read side
    input  wire logic          rclk,
    input  wire logic          rrst,
    input  wire logic          r_pop,
    output logic               r_valid,
    output logic [DW-1:0]      r_data,
    output logic [AW:0]        r_count
);
    localparam int          DEPTH   = 1 << AW;
    localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_V   = (AW+1)'(1);

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [AW:0] b2g(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // one state struct per clock domain
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [AW:0]              ptr;
        logic [AW:0]              gray;
        logic [AW:0]              cnt;
        logic                     rdy;
    } jcf_wr_st_t;

    typedef struct packed {
        logic [AW:0] ptr;
        logic [AW:0] gray;
        logic [AW:0] cnt;
        logic        vld;
    } jcf_rd_st_t;

    jcf_wr_st_t w_ff;
    jcf_wr_st_t nxt_w;
    jcf_rd_st_t r_ff;
    jcf_rd_st_t nxt_r;
    logic [AW:0] rgray_w;
    logic [AW:0] wgray_r;

    jcf_sync #(.W(AW+1)) u_r2w (.clk(wclk), .rst(wrst), .d(r_ff.gray), .q(rgray_w));
    jcf_sync #(.W(AW+1)) u_w2r (.clk(rclk), .rst(rrst), .d(w_ff.gray), .q(wgray_r));

    // counts use the lagging far pointer, so they err on the safe side
    always_comb begin
        nxt_w = w_ff;
        if (w_push && w_ff.rdy) begin
            nxt_w.mem[w_ff.ptr[AW-1:0]] = w_data;
            nxt_w.ptr = w_ff.ptr + ONE_V;
        end
        nxt_w.gray = b2g(nxt_w.ptr);
        nxt_w.cnt  = nxt_w.ptr - g2b(rgray_w);
        nxt_w.rdy  = nxt_w.cnt != DEPTH_V;
        if (wrst) begin
            nxt_w     = '0;
            nxt_w.rdy = 1'b1;
        end
    end

    always_comb begin
        nxt_r = r_ff;
        if (r_pop && r_ff.vld) begin
            nxt_r.ptr = r_ff.ptr + ONE_V;
        end
        nxt_r.gray = b2g(nxt_r.ptr);
        nxt_r.cnt  = g2b(wgray_r) - nxt_r.ptr;
        nxt_r.vld  = nxt_r.cnt != '0;
        if (rrst) begin
            nxt_r = '0;
        end
    end

    always_ff @(posedge wclk) begin
        w_ff <= nxt_w;
    end

    always_ff @(posedge rclk) begin
        r_ff <= nxt_r;
    end

    assign w_ready = w_ff.rdy;
    assign w_count = w_ff.cnt;
    assign r_valid = r_ff.vld;
    assign r_count = r_ff.cnt;
    // slot is stable: its write was seen through the pointer crossing
    assign r_data  = w_ff.mem[r_ff.ptr[AW-1:0]];

    full_keeps_a: assert property (@(posedge wclk) disable iff (wrst)
        (w_push && !w_ff.rdy) |=> (w_ff.ptr == $past(w_ff.ptr)))
        else $error("push into a full fifo moved the pointer");

    count_bound_a: assert property (@(posedge rclk) disable iff (rrst)
        (r_ff.cnt <= DEPTH_V) && (r_ff.vld == (r_ff.cnt != '0)))
        else $error("read side count out of range");
endmodule

// ---- verif/jcf_host_model.sv ----
`timescale 1ns/1ps
module jcf_host_model import jcf_pkg::*; (
    // link clock
    input  wire logic              tck,
    // host to read fifo
    output logic                   host_wr_valid,
    output logic      [CHAR_W-1:0] host_wr_data,
    input  wire logic              host_wr_ready,
    // write fifo to host
    output logic                   host_rd_req,
    input  wire logic [CHAR_W-1:0] host_rd_data,
    input  wire logic              host_rd_strobe,
    input  wire logic              host_rd_avail,
    // activity and end of stream
    output logic                   host_poll,
    output logic                   host_eof
);
    initial begin
        host_wr_valid = 1'b0;
        host_wr_data  = 8'hA5;
        host_rd_req   = 1'b0;
        host_poll     = 1'b0;
        host_eof      = 1'b0;
    end

    // offer held until an edge sees ready or 20 edges pass; data inverted once released
    task automatic send(input logic [CHAR_W-1:0] ch, output logic ok);
        int n;
        n  = 0;
        ok = 1'b0;
        @(posedge tck);
        #1;
        host_wr_valid = 1'b1;
        host_wr_data  = ch;
        while (ok !== 1'b1 && n < 20) begin
            @(posedge tck);
            ok = host_wr_ready;
            n++;
        end
        #1;
        host_wr_valid = 1'b0;
        host_wr_data  = ~ch;
    endtask

    // request raised once a char is offered or after 40 edges without one; an offered char is taken at the next edge
    task automatic recv(output logic [CHAR_W-1:0] ch, output logic ok);
        int n;
        n = 0;
        while (host_rd_avail !== 1'b1 && n < 40) begin
            @(posedge tck);
            n++;
        end
        #1;
        host_rd_req = 1'b1;
        @(posedge tck);
        #1;
        // strobe stands for one tck only: take it before the next edge
        ok = host_rd_strobe;
        ch = host_rd_data;
        host_rd_req = 1'b0;
    endtask

    task automatic poll();
        @(posedge tck);
        #1;
        host_poll = 1'b1;
        @(posedge tck);
        #1;
        host_poll = 1'b0;
    endtask

    task automatic set_eof(input logic v);
        @(posedge tck);
        #1;
        host_eof = v;
    endtask
endmodule

// ---- verif/tb_jtag_char_fifo_port.sv ----
`timescale 1ns/1ps
module tb_jtag_char_fifo_port import jcf_pkg::*;;
    // small fifo keeps fill and drain short
    localparam int DEPTH = 8;
    localparam int RT    = 2;
    localparam int WT    = 2;

    logic              clk = 1'b0;
    logic              tck = 1'b1;
    logic              sys_rst;
    logic              reg_cs;
    logic [0:0]        reg_addr;
    logic              reg_rd;
    logic              reg_wr;
    logic [31:0]       reg_wdata;
    logic [31:0]       reg_rdata;
    logic              reg_rdvalid;
    logic              irq;
    logic              host_wr_valid;
    logic [CHAR_W-1:0] host_wr_data;
    logic              host_wr_ready;
    logic              host_rd_req;
    logic [CHAR_W-1:0] host_rd_data;
    logic              host_rd_strobe;
    logic              host_rd_avail;
    logic              host_poll;
    logic              host_eof;
    int                fail_count = 0;
    int                checked = 0;

    always #5 clk = ~clk;
    always #6 tck = ~tck;

    jcf_jtag_char_port #(.FIFO_AW(3), .RD_THRESH(RT), .WR_THRESH(WT)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_cs(reg_cs), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdvalid(reg_rdvalid),
        .irq(irq), .tck(tck), .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data),
        .host_wr_ready(host_wr_ready), .host_rd_req(host_rd_req), .host_rd_data(host_rd_data),
        .host_rd_strobe(host_rd_strobe), .host_rd_avail(host_rd_avail), .host_poll(host_poll),
        .host_eof(host_eof));

    jcf_host_model i_host (
        .tck(tck), .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data),
        .host_wr_ready(host_wr_ready), .host_rd_req(host_rd_req), .host_rd_data(host_rd_data),
        .host_rd_strobe(host_rd_strobe), .host_rd_avail(host_rd_avail), .host_poll(host_poll),
        .host_eof(host_eof));

    task automatic end_sim();
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] dexp(input int n, input logic [7:0] ch);
        return {16'(n), 8'h80, ch};
    endfunction

    function automatic logic [31:0] cexp(input int fr, input logic ac, wi, ri, we, re);
        return {16'(fr), 5'h00, ac, wi, ri, 6'h00, we, re};
    endfunction

    // one-cycle strobes; the next access starts at a later edge
    task automatic bus_wr(input logic [0:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_cs    = 1'b1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_cs    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic bus_rd(input logic [0:0] a, input logic [31:0] exp);
        @(posedge clk);
        #1;
        reg_cs   = 1'b1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_cs   = 1'b0;
        reg_rd   = 1'b0;
        check(32'(reg_rdvalid), 32'h1);
        check(reg_rdata, exp);
    endtask

    // crossings lag a few edges; irq one more
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        check(32'(irq), 32'h0);
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 0, 0, 0, 0));
        bus_rd(DATA_REG_IDX, 32'h0);
    endtask

    task automatic t_host_to_bus();
        logic ok;
        for (int i = 0; i < 3; i++) begin
            i_host.send(8'hA1 + 8'(i), ok);
            check(32'(ok), 32'h1);
        end
        settle();
        for (int i = 0; i < 3; i++) begin
            bus_rd(DATA_REG_IDX, dexp(2 - i, 8'hA1 + 8'(i)));
        end
        bus_rd(DATA_REG_IDX, 32'h0);
    endtask

    task automatic t_bus_to_host();
        logic ok;
        logic [7:0] ch;
        bus_wr(CTRL_REG_IDX, 32'h2);
        settle();
        check(32'(irq), 32'h1);
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 1, 0, 1, 0));
        for (int i = 0; i <= DEPTH; i++) begin
            bus_wr(DATA_REG_IDX, {24'h0, 8'h10 + 8'(i)});
            settle();
            check(32'(irq), (i < WT) ? 32'h1 : 32'h0);
        end
        bus_rd(CTRL_REG_IDX, cexp(0, 0, 0, 0, 1, 0));
        bus_wr(CTRL_REG_IDX, 32'h0);
        for (int i = 0; i < DEPTH; i++) begin
            i_host.recv(ch, ok);
            check({23'h0, ok, ch}, {23'h0, 1'b1, 8'h10 + 8'(i)});
        end
        i_host.recv(ch, ok);
        check(32'(ok), 32'h0);
        settle();
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 0, 0, 0, 0));
    endtask

    task automatic t_read_irq();
        logic ok;
        bus_wr(CTRL_REG_IDX, 32'h1);
        for (int i = 0; i < DEPTH - RT; i++) begin
            i_host.send(8'h40 + 8'(i), ok);
            settle();
            check(32'(irq), (i == DEPTH - RT - 1) ? 32'h1 : 32'h0);
        end
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 0, 1, 0, 1));
        bus_rd(DATA_REG_IDX, dexp(DEPTH - RT - 1, 8'h40));
        settle();
        check(32'(irq), 32'h0);
        i_host.set_eof(1'b1);
        settle();
        check(32'(irq), 32'h1);
        for (int i = 1; i < DEPTH - RT; i++) begin
            bus_rd(DATA_REG_IDX, dexp(DEPTH - RT - 1 - i, 8'h40 + 8'(i)));
        end
        settle();
        check(32'(irq), 32'h0);
        i_host.set_eof(1'b0);
        bus_wr(CTRL_REG_IDX, 32'h0);
    endtask

    task automatic t_poll();
        i_host.poll();
        settle();
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 1, 0, 0, 0, 0));
        bus_wr(CTRL_REG_IDX, 32'h0000_0403);
        settle();
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 1, 0, 1, 1));
        check(32'(irq), 32'h1);
        bus_wr(CTRL_REG_IDX, 32'h0000_0301);
        settle();
        bus_rd(CTRL_REG_IDX, cexp(DEPTH, 0, 0, 0, 0, 1));
        check(32'(irq), 32'h0);
        bus_wr(CTRL_REG_IDX, 32'h0);
    endtask

    initial begin
        sys_rst   = 1'b1;
        reg_cs    = 1'b0;
        reg_addr  = 1'b0;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 32'h0;
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge tck);
        t_reset();
        t_host_to_bus();
        t_bus_to_host();
        t_read_irq();
        t_poll();
        end_sim();
    end

    // the whole run takes well under a tenth of this
    initial begin
        #300000;
        fail_count++;
        end_sim();
    end
endmodule
